// [common/aas_consts.svh]
// Widths, status bit positions and reset values for the accumulator datapath
`ifndef AAS_CONSTS_SVH
`define AAS_CONSTS_SVH
// ************************************************************
// Widths
// ************************************************************
`define AAS_DW 16
`define AAS_AW 32
`define AAS_SHW 5
`define AAS_SH_MAX 5'h10
`define AAS_STW 3
// ************************************************************
// Status word layout and reset values
// ************************************************************
`define AAS_ST_SEXT 0
`define AAS_ST_TC 1
`define AAS_ST_C 2
`define AAS_ST_OV 3
`define AAS_SEXT_RST 1'h1
`define AAS_ACC_RST 32'h0000_0000
`endif

// [common/aas_pkg.sv]
// Types shared by the accumulator datapath modules
package aas_pkg;
  // Datapath operations issued by the instruction decoder
  typedef enum logic [3:0] {
    AAS_NOP, AAS_LOAD, AAS_ADD, AAS_SUB, AAS_AND, AAS_OR, AAS_XOR,
    AAS_STORE_HI, AAS_STORE_LO, AAS_NORM, AAS_BIT_TEST, AAS_BRANCH_ACC,
    AAS_SET_SEXT, AAS_CLR_SEXT, AAS_LOAD_ST
  } aas_op_e;
  // Product path justification modes
  typedef enum logic [1:0] {AAS_PM_NONE, AAS_PM_LEFT1, AAS_PM_LEFT4, AAS_PM_RIGHT6} aas_pmode_e;
  // Branch conditions
  typedef enum logic [2:0] {AAS_C_ALWAYS, AAS_C_EQ, AAS_C_NEQ, AAS_C_LT, AAS_C_GT, AAS_C_OV, AAS_C_TC,
    AAS_C_NTC} aas_cond_e;
endpackage

// [design/aas_scale_shift.sv]
// Input scaling shifter: 16-bit word to 32-bit left-shifted operand
`include "aas_consts.svh"
module aas_scale_shift (
  input wire logic [`AAS_DW-1:0] data,
  input wire logic [`AAS_SHW-1:0] amt,
  input wire logic sign_ext,
  output logic [`AAS_AW-1:0] scaled
);
  logic [`AAS_AW-1:0] ext;
  logic [`AAS_SHW-1:0] eff;
  // Fill upper bits by mode, clamp amount, zero fill from the bottom
  // 0..16 left, zero below
  always_comb begin
    ext = sign_ext ? {{`AAS_DW{data[`AAS_DW-1]}}, data} : {{`AAS_DW{1'b0}}, data};
    eff = (amt > `AAS_SH_MAX) ? `AAS_SH_MAX : amt;
    scaled = ext << eff;
  end
endmodule

// [design/aas_prod_shift.sv]
// Product register output shifter with four justification modes
module aas_prod_shift (
  input wire logic [31:0] prod,
  input wire aas_pkg::aas_pmode_e mode,
  output logic [31:0] shifted
);
  // Right shift keeps the sign so scaled-down products stay signed
  // four justification modes
  always_comb begin
    unique case (mode)
      aas_pkg::AAS_PM_NONE: shifted = prod;
      aas_pkg::AAS_PM_LEFT1: shifted = {prod[30:0], 1'b0};
      aas_pkg::AAS_PM_LEFT4: shifted = {prod[27:0], 4'h0};
      aas_pkg::AAS_PM_RIGHT6: shifted = {{6{prod[31]}}, prod[31:6]};
    endcase
  end
endmodule

// [design/aas_datapath.sv]
// Accumulator, ALU, store shifters, normalize, bit test and branch support
`include "aas_consts.svh"
module aas_datapath (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic op_valid,
  input wire aas_pkg::aas_op_e op,
  input wire logic src_prod,
  input wire logic [`AAS_SHW-1:0] shift_amt,
  input wire logic [`AAS_DW-1:0] data_in,
  input wire logic [3:0] bit_sel,
  input wire logic [`AAS_STW-1:0] store_shift,
  input wire aas_pkg::aas_pmode_e pmode,
  input wire logic mult_load,
  input wire logic [31:0] mult_product,
  input wire aas_pkg::aas_cond_e cond_sel,
  output logic [`AAS_AW-1:0] acc,
  output logic [31:0] product_holding_reg,
  output logic [`AAS_DW-1:0] data_out,
  output logic data_out_valid,
  output logic [`AAS_DW-1:0] branch_target,
  output logic branch_valid,
  output logic norm_done,
  output logic sign_extend_select,
  output logic [`AAS_DW-1:0] status_word_zero,
  output logic cond_true
);
  // ************************************************************
  // Functions
  // ************************************************************
  // Store shifter: left shift, then pick a half
  function automatic logic [15:0] store_half(input logic [31:0] a, input logic [2:0] sh, input logic hi);
    logic [31:0] s;
    s = a << sh;
    store_half = hi ? s[31:16] : s[15:0];
  endfunction

  // Sign of a 32-bit value, used by ALU flags and conditions
  function automatic logic is_neg(input logic [31:0] a);
    is_neg = a[31];
  endfunction

  // ************************************************************
  // Operand paths
  // ************************************************************
  logic [31:0] scaled;
  logic [31:0] prod_sh;
  logic [31:0] opnd_b;
  logic tc;
  logic carry;
  logic ovf;

  aas_scale_shift u_scale (
    .data(data_in),
    .amt(shift_amt),
    .sign_ext(sign_extend_select),
    .scaled(scaled)
  );

  aas_prod_shift u_prod (
    .prod(product_holding_reg),
    .mode(pmode),
    .shifted(prod_sh)
  );

  // Second operand select
  // operand b select
  assign opnd_b = src_prod ? prod_sh : scaled;

  // ************************************************************
  // Next state
  // ************************************************************
  logic [31:0] next_acc;
  logic [31:0] next_prod;
  logic [15:0] next_data_out;
  logic next_data_out_valid;
  logic [15:0] next_branch_target;
  logic next_branch_valid;
  logic next_norm_done;
  logic next_sign_ext;
  logic next_tc;
  logic next_carry;
  logic next_ovf;
  logic [32:0] sum;
  logic [32:0] diff;

  // One decode per cycle; every ALU result lands in the same edge
  always_comb begin
    sum = {1'b0, acc} + {1'b0, opnd_b};
    diff = {1'b0, acc} - {1'b0, opnd_b};
    next_acc = acc;
    next_prod = mult_load ? mult_product : product_holding_reg;
    next_data_out = data_out;
    next_data_out_valid = 1'b0;
    next_branch_target = branch_target;
    next_branch_valid = 1'b0;
    next_norm_done = norm_done;
    next_sign_ext = sign_extend_select;
    next_tc = tc;
    next_carry = carry;
    next_ovf = ovf;
    if (op_valid) begin
      unique case (op)
        aas_pkg::AAS_NOP: begin
        end
        aas_pkg::AAS_LOAD: next_acc = opnd_b;
        aas_pkg::AAS_ADD: begin
          next_acc = sum[31:0];
          next_carry = sum[32];
          next_ovf = (is_neg(acc) == is_neg(opnd_b)) && (is_neg(sum[31:0]) != is_neg(acc));
        end
        aas_pkg::AAS_SUB: begin
          next_acc = diff[31:0];
          next_carry = ~diff[32];
          next_ovf = (is_neg(acc) != is_neg(opnd_b)) && (is_neg(diff[31:0]) != is_neg(acc));
        end
        aas_pkg::AAS_AND: next_acc = acc & opnd_b;
        aas_pkg::AAS_OR: next_acc = acc | opnd_b;
        aas_pkg::AAS_XOR: next_acc = acc ^ opnd_b;
        aas_pkg::AAS_STORE_HI: begin
          next_data_out = store_half(acc, store_shift, 1'b1);
          next_data_out_valid = 1'b1;
        end
        // lower half shifted on the way out
        aas_pkg::AAS_STORE_LO: begin
          next_data_out = store_half(acc, store_shift, 1'b0);
          next_data_out_valid = 1'b1;
        end
        aas_pkg::AAS_NORM: begin
          if ((acc != 32'h0000_0000) && (acc[31] == acc[30])) begin
            next_acc = {acc[30:0], 1'b0};
            next_norm_done = 1'b0;
          end else begin
            next_norm_done = 1'b1;
          end
        end
        // test one bit of the bus word
        aas_pkg::AAS_BIT_TEST: next_tc = data_in[bit_sel];
        aas_pkg::AAS_BRANCH_ACC: begin
          next_branch_target = acc[15:0];
          next_branch_valid = 1'b1;
        end
        // software sets or clears the mode
        aas_pkg::AAS_SET_SEXT: next_sign_ext = 1'b1;
        aas_pkg::AAS_CLR_SEXT: next_sign_ext = 1'b0;
        aas_pkg::AAS_LOAD_ST: begin
          next_sign_ext = data_in[`AAS_ST_SEXT];
          next_tc = data_in[`AAS_ST_TC];
          next_carry = data_in[`AAS_ST_C];
          next_ovf = data_in[`AAS_ST_OV];
        end
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // single-cycle update
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc <= `AAS_ACC_RST;
      product_holding_reg <= 32'h0000_0000;
      data_out <= 16'h0000;
      data_out_valid <= 1'b0;
      branch_target <= 16'h0000;
      branch_valid <= 1'b0;
      norm_done <= 1'b0;
      sign_extend_select <= `AAS_SEXT_RST;
      tc <= 1'b0;
      carry <= 1'b0;
      ovf <= 1'b0;
    end else begin
      acc <= next_acc;
      product_holding_reg <= next_prod;
      data_out <= next_data_out;
      data_out_valid <= next_data_out_valid;
      branch_target <= next_branch_target;
      branch_valid <= next_branch_valid;
      norm_done <= next_norm_done;
      sign_extend_select <= next_sign_ext;
      tc <= next_tc;
      carry <= next_carry;
      ovf <= next_ovf;
    end
  end

  // ************************************************************
  // Status word and branch condition
  // ************************************************************
  // Status readback; unused bits read zero
  always_comb begin
    status_word_zero = 16'h0000;
    status_word_zero[`AAS_ST_SEXT] = sign_extend_select;
    status_word_zero[`AAS_ST_TC] = tc;
    status_word_zero[`AAS_ST_C] = carry;
    status_word_zero[`AAS_ST_OV] = ovf;
  end

  // Zero and sign conditions come from live accumulator so a branch after an op sees its result
  // condition select
  always_comb begin
    unique case (cond_sel)
      aas_pkg::AAS_C_ALWAYS: cond_true = 1'b1;
      aas_pkg::AAS_C_EQ: cond_true = (acc == 32'h0000_0000);
      aas_pkg::AAS_C_NEQ: cond_true = (acc != 32'h0000_0000);
      aas_pkg::AAS_C_LT: cond_true = is_neg(acc);
      aas_pkg::AAS_C_GT: cond_true = !is_neg(acc) && (acc != 32'h0000_0000);
      aas_pkg::AAS_C_OV: cond_true = ovf;
      aas_pkg::AAS_C_TC: cond_true = tc;
      aas_pkg::AAS_C_NTC: cond_true = !tc;
    endcase
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic [31:0] zext;
  logic [31:0] sext;
  logic is_load_sh;
  assign zext = {16'h0000, data_in};
  assign sext = {{16{data_in[15]}}, data_in};
  assign is_load_sh = op_valid && (op == aas_pkg::AAS_LOAD) && !src_prod && (shift_amt <= 5'h10);

  AST_ZERO_EXT_LOAD: assert property (is_load_sh && !sign_extend_select |=> acc == ($past(zext) << $past(shift_amt)))
    else $error("zero-extended scaled load wrong");
  AST_LOW_ZERO: assert property (is_load_sh && (shift_amt != 5'h00) |=> acc[0] == 1'b0)
    else $error("vacated low bit not zero");
  AST_SIGN_EXT_LOAD: assert property (is_load_sh && sign_extend_select |=> acc == ($past(sext) << $past(shift_amt)))
    else $error("sign-extended scaled load wrong");
  AST_SIGNED_VALUE: assert property (is_load_sh && sign_extend_select && (shift_amt == 5'h10)
    |=> acc[31] == $past(data_in[15]) && acc[15:0] == 16'h0000)
    else $error("signed scaling lost sign");
  AST_ADD_SHIFTER: assert property (op_valid && op == aas_pkg::AAS_ADD && !src_prod
    |=> acc == $past(acc) + $past(scaled))
    else $error("add from shifter wrong");
  AST_ADD_PRODUCT: assert property (op_valid && op == aas_pkg::AAS_ADD && src_prod
    |=> acc == $past(acc) + $past(prod_sh))
    else $error("add from product path wrong");
  AST_XOR_WB: assert property (op_valid && op == aas_pkg::AAS_XOR |=> acc == ($past(acc) ^ $past(opnd_b)))
    else $error("logic result not written back");
  AST_STORE_HI: assert property (op_valid && op == aas_pkg::AAS_STORE_HI
    |=> data_out_valid && data_out == $past(store_half(acc, store_shift, 1'b1)))
    else $error("upper store wrong");
  AST_STORE_LO_SHIFT: assert property (op_valid && op == aas_pkg::AAS_STORE_LO && store_shift == 3'h1
    |=> data_out == {$past(acc[14:0]), 1'b0})
    else $error("lower store shift wrong");
  AST_STORE_KEEP: assert property (op_valid && (op == aas_pkg::AAS_STORE_HI || op == aas_pkg::AAS_STORE_LO)
    |=> $stable(acc))
    else $error("store changed accumulator");
  AST_BRANCH: assert property (op_valid && op == aas_pkg::AAS_BRANCH_ACC
    |=> branch_valid && branch_target == $past(acc[15:0]))
    else $error("branch target wrong");
  AST_NORM: assert property (op_valid && op == aas_pkg::AAS_NORM && acc[31] != acc[30]
    |=> $stable(acc) && norm_done)
    else $error("normalize on normalized value");
  AST_BIT_TEST: assert property (op_valid && op == aas_pkg::AAS_BIT_TEST
    ##1 cond_sel == aas_pkg::AAS_C_TC |-> cond_true == $past(data_in[bit_sel]))
    else $error("bit test wrong");
  AST_COND_EQ: assert property (cond_sel == aas_pkg::AAS_C_EQ |-> cond_true == (acc == 32'h0000_0000))
    else $error("zero condition wrong");
  AST_PROD_LOAD: assert property (mult_load |=> product_holding_reg == $past(mult_product))
    else $error("product not captured");
  AST_PM_RIGHT6: assert property (pmode == aas_pkg::AAS_PM_RIGHT6
    |-> prod_sh == {{6{product_holding_reg[31]}}, product_holding_reg[31:6]})
    else $error("product shift mode wrong");
  AST_SEXT_NEXT: assert property (op_valid && op == aas_pkg::AAS_SET_SEXT ##1 is_load_sh
    |=> acc == ($past(sext) << $past(shift_amt)))
    else $error("mode not effective next op");
  AST_ONE_CYCLE: assert property (op_valid && op == aas_pkg::AAS_SUB |=> acc == $past(acc) - $past(opnd_b))
    else $error("subtract late or wrong");

  COV_SEXT_LOAD: cover property (is_load_sh && sign_extend_select && data_in[15]);
  COV_MAC: cover property (mult_load ##1 op_valid && op == aas_pkg::AAS_ADD && src_prod);
  COV_STORE_PAIR: cover property (op_valid && op == aas_pkg::AAS_STORE_HI ##1 op_valid && op == aas_pkg::AAS_STORE_LO);
  COV_NORM_DONE: cover property (norm_done && !$past(norm_done));
endmodule

// [dv/aas_dec_model.sv]
// Decoder and data bus model that feeds operations to the datapath
module aas_dec_model (
  input wire logic core_clk,
  output logic op_valid,
  output aas_pkg::aas_op_e op,
  output logic src_prod,
  output logic [4:0] shift_amt,
  output logic [15:0] data_in,
  output logic [3:0] bit_sel,
  output logic [2:0] store_shift,
  output aas_pkg::aas_pmode_e pmode,
  output logic mult_load,
  output logic [31:0] mult_product,
  output aas_pkg::aas_cond_e cond_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ml_pend;
  // Quiet bus at time zero
  initial begin
    {op_valid, src_prod, shift_amt, data_in, bit_sel, store_shift, mult_load, mult_product} = '0;
    op = aas_pkg::AAS_NOP;
    pmode = aas_pkg::AAS_PM_NONE;
    cond_sel = aas_pkg::AAS_C_ALWAYS;
    ml_pend = 1'h0;
  end
  // Side fields wait in place until the next issue
  task automatic cfg(input logic [3:0] b, input logic [2:0] s, input aas_pkg::aas_pmode_e p,
                     input aas_pkg::aas_cond_e c);
    @(negedge core_clk);
    op_valid <= 1'h0;
    mult_load <= 1'h0;
    bit_sel <= b;
    store_shift <= s;
    pmode <= p;
    cond_sel <= c;
  endtask
  task automatic mult(input logic [31:0] p);
    mult_product <= p;
    ml_pend = 1'h1;
  endtask
  task automatic issue(input aas_pkg::aas_op_e o, input logic sp, input logic [4:0] sh, input logic [15:0] d);
    @(negedge core_clk);
    op_valid <= 1'h1;
    op <= o;
    src_prod <= sp;
    shift_amt <= sh;
    data_in <= d;
    mult_load <= ml_pend;
    ml_pend = 1'h0;
    @(posedge core_clk);
    #1;
  endtask
  // Released bus shows a changed pattern, never the old word
  task automatic idle();
    @(negedge core_clk);
    op_valid <= 1'h0;
    mult_load <= 1'h0;
    data_in <= ~data_in;
    mult_product <= ~mult_product;
    @(posedge core_clk);
    #1;
  endtask
endmodule

// [dv/testbench.sv]
// Self-checking bench for the accumulator datapath
`include "aas_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0, arst_n = 1'h0, op_valid, src_prod, mult_load;
  aas_pkg::aas_op_e op;
  aas_pkg::aas_pmode_e pmode;
  aas_pkg::aas_cond_e cond_sel;
  logic [4:0] shift_amt;
  logic [15:0] data_in, data_out, branch_target, status_word_zero;
  logic [3:0] bit_sel;
  logic [2:0] store_shift;
  logic [31:0] mult_product, acc, product_holding_reg, e;
  logic data_out_valid, branch_valid, norm_done, sign_extend_select, cond_true;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  aas_dec_model aas_dec_model_inst (.core_clk(core_clk), .op_valid(op_valid), .op(op), .src_prod(src_prod),
    .shift_amt(shift_amt), .data_in(data_in), .bit_sel(bit_sel), .store_shift(store_shift), .pmode(pmode),
    .mult_load(mult_load), .mult_product(mult_product), .cond_sel(cond_sel));
  aas_datapath aas_datapath_inst (.core_clk(core_clk), .arst_n(arst_n), .op_valid(op_valid), .op(op),
    .src_prod(src_prod), .shift_amt(shift_amt), .data_in(data_in), .bit_sel(bit_sel), .store_shift(store_shift),
    .pmode(pmode), .mult_load(mult_load), .mult_product(mult_product), .cond_sel(cond_sel), .acc(acc),
    .product_holding_reg(product_holding_reg), .data_out(data_out), .data_out_valid(data_out_valid),
    .branch_target(branch_target), .branch_valid(branch_valid), .norm_done(norm_done),
    .sign_extend_select(sign_extend_select), .status_word_zero(status_word_zero), .cond_true(cond_true));
  // 25 ns clock, 40 MHz
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // Hang guard: whole run needs well under 1000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end
  // Expected scaling result, clamped above sixteen
  function automatic logic [31:0] scl(input logic [15:0] d, input logic [4:0] a, input logic s);
    logic [31:0] w;
    w = s ? {{16{d[15]}}, d} : {16'h0000, d};
    return w << ((a > 5'h10) ? 5'h10 : a);
  endfunction
  task automatic t_reset();
    `CHK(acc, `AAS_ACC_RST)
    `CHK(sign_extend_select, `AAS_SEXT_RST)
    `CHK(status_word_zero, 16'h0001)
    `CHK({data_out_valid, branch_valid, norm_done}, 3'h0)
    $display("test reset done");
  endtask
  task automatic t_scale();
    logic [4:0] amts [6] = '{5'h00, 5'h01, 5'h0F, 5'h10, 5'h14, 5'h04};
    for (int s = 1; s >= 0; s--) begin
      aas_dec_model_inst.issue(s ? aas_pkg::AAS_SET_SEXT : aas_pkg::AAS_CLR_SEXT, 1'h0, 5'h00, 16'h0000);
      `CHK(sign_extend_select, s[0])
      for (int i = 0; i < 6; i++) begin
        aas_dec_model_inst.issue(aas_pkg::AAS_LOAD, 1'h0, amts[i], 16'h8001);
        `CHK(acc, scl(16'h8001, amts[i], s[0]))
        aas_dec_model_inst.issue(aas_pkg::AAS_LOAD, 1'h0, amts[i], 16'h7FFE);
        `CHK(acc, scl(16'h7FFE, amts[i], s[0]))
      end
    end
    $display("test scale done");
  endtask
  task automatic t_alu();
    aas_pkg::aas_op_e ops [5] = '{aas_pkg::AAS_ADD, aas_pkg::AAS_SUB, aas_pkg::AAS_AND, aas_pkg::AAS_OR,
      aas_pkg::AAS_XOR};
    logic [31:0] b;
    aas_dec_model_inst.issue(aas_pkg::AAS_LOAD, 1'h0, 5'h08, 16'hF0F3);
    e = 32'h00F0_F300;
    b = 32'h0001_2340;
    // Back to back, one result each cycle
    for (int i = 0; i < 5; i++) begin
      aas_dec_model_inst.issue(ops[i], 1'h0, 5'h04, 16'h1234);
      case (i)
        0: e = e + b;
        1: e = e - b;
        2: e = e & b;
        3: e = e | b;
        default: e = e ^ b;
      endcase
      `CHK(acc, e)
    end
    $display("test alu done");
  endtask
  task automatic t_prod();
    logic [31:0] p = 32'h8123_4567;
    aas_dec_model_inst.mult(p);
    aas_dec_model_inst.idle();
    aas_dec_model_inst.idle();
    `CHK(product_holding_reg, 32'h0000_0000)
    aas_dec_model_inst.mult(p);
    aas_dec_model_inst.issue(aas_pkg::AAS_NOP, 1'h0, 5'h00, 16'h0000);
    `CHK(product_holding_reg, p)
    for (int m = 0; m < 4; m++) begin
      aas_dec_model_inst.cfg(4'h0, 3'h0, aas_pkg::aas_pmode_e'(m), aas_pkg::AAS_C_ALWAYS);
      aas_dec_model_inst.issue(aas_pkg::AAS_LOAD, 1'h1, 5'h00, 16'h5555);
      e = (m == 0) ? p : (m == 1) ? p << 1 : (m == 2) ? p << 4 : {{6{p[31]}}, p[31:6]};
      `CHK(acc, e)
    end
    $display("test product done");
  endtask
  task automatic t_store();
    for (int s = 0; s < 8; s += 7) begin
      for (int h = 1; h >= 0; h--) begin
        e = acc << s;
        aas_dec_model_inst.cfg(4'h0, 3'(s), aas_pkg::AAS_PM_NONE, aas_pkg::AAS_C_ALWAYS);
        aas_dec_model_inst.issue(h ? aas_pkg::AAS_STORE_HI : aas_pkg::AAS_STORE_LO, 1'h0, 5'h00, 16'h0000);
        `CHK(data_out, h ? e[31:16] : e[15:0])
        `CHK(data_out_valid, 1'h1)
        `CHK(acc << s, e)
      end
    end
    aas_dec_model_inst.idle();
    `CHK(data_out_valid, 1'h0)
    $display("test store done");
  endtask
  task automatic t_branch();
    logic [7:0] cexp = 8'h83;
    aas_dec_model_inst.issue(aas_pkg::AAS_LOAD, 1'h0, 5'h00, 16'hBEEF);
    aas_dec_model_inst.issue(aas_pkg::AAS_BRANCH_ACC, 1'h0, 5'h00, 16'h0000);
    `CHK({branch_valid, branch_target}, {1'h1, 16'hBEEF})
    aas_dec_model_inst.idle();
    `CHK(branch_valid, 1'h0)
    aas_dec_model_inst.issue(aas_pkg::AAS_SUB, 1'h0, 5'h00, 16'hBEEF);
    for (int c = 0; c < 8; c++) begin
      aas_dec_model_inst.cfg(4'h0, 3'h0, aas_pkg::AAS_PM_NONE, aas_pkg::aas_cond_e'(c));
      aas_dec_model_inst.issue(aas_pkg::AAS_NOP, 1'h0, 5'h00, 16'h0000);
      `CHK(cond_true, cexp[c])
    end
    $display("test branch done");
  endtask
  task automatic t_norm();
    int n = 0;
    aas_dec_model_inst.issue(aas_pkg::AAS_LOAD, 1'h0, 5'h00, 16'h1000);
    while (norm_done !== 1'h1 && n < 40) begin
      aas_dec_model_inst.issue(aas_pkg::AAS_NORM, 1'h0, 5'h00, 16'h0000);
      n++;
    end
    `CHK(n, 19)
    `CHK(acc, 32'h4000_0000)
    $display("test normalize done");
  endtask
  task automatic t_bit();
    logic [15:0] d = 16'hA5C3;
    for (int i = 0; i < 16; i++) begin
      aas_dec_model_inst.cfg(4'(i), 3'h0, aas_pkg::AAS_PM_NONE, (i == 5) ? aas_pkg::AAS_C_NTC : aas_pkg::AAS_C_TC);
      aas_dec_model_inst.issue(aas_pkg::AAS_BIT_TEST, 1'h0, 5'h00, d);
      `CHK(status_word_zero[`AAS_ST_TC], d[i])
      `CHK(cond_true, (i == 5) ? ~d[i] : d[i])
    end
    aas_dec_model_inst.issue(aas_pkg::AAS_LOAD_ST, 1'h0, 5'h00, 16'h0005);
    `CHK(status_word_zero, 16'h0005)
    $display("test bit done");
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'h1;
    t_reset();
    t_scale();
    t_alu();
    t_prod();
    t_store();
    t_branch();
    t_norm();
    t_bit();
    results();
  end
endmodule
